/* pkg/tt_pkg.sv */
// Constants for the third timer/counter: register map, bit fields,
// reset values and the phase timing of the machine cycle.
// Assumes the oscillator clock is the block clock clk_sys.
package tt_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned OSC_PER_MACH  = 12;  // Oscillator periods per machine cycle
  localparam int unsigned OSC_PER_STATE = 2;   // Oscillator periods per state time
  localparam logic [3:0]  PH_LAST    = 4'(OSC_PER_MACH - 1);
  localparam logic [3:0]  PH_SAMPLE  = 4'h9;   // state5_phase2
  localparam logic [3:0]  PH_VISIBLE = 4'h4;   // state3_phase1
  localparam logic [3:0]  BAUD_DIV_LAST = 4'hf; // Divide rollovers by 16

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_CTRL   = 8'hc8;
  localparam logic [7:0] IDX_MODE   = 8'hc9;
  localparam logic [7:0] IDX_RCAP_L = 8'hca;
  localparam logic [7:0] IDX_RCAP_H = 8'hcb;
  localparam logic [7:0] IDX_CNT_L  = 8'hcc;
  localparam logic [7:0] IDX_CNT_H  = 8'hcd;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CB_OVF   = 7;  // overflow_flag
  localparam int unsigned CB_EXT   = 6;  // external_edge_flag
  localparam int unsigned CB_RXB   = 5;  // receive baud select
  localparam int unsigned CB_TXB   = 4;  // transmit_baud_select
  localparam int unsigned CB_EXEN  = 3;  // external_trigger_enable
  localparam int unsigned CB_RUN   = 2;  // run_control
  localparam int unsigned CB_CT    = 1;  // counter_timer_select
  localparam int unsigned CB_CPRL  = 0;  // capture_reload_select
  localparam int unsigned MB_OE    = 1;  // clock_out_enable
  localparam int unsigned MB_DOWN  = 0;  // down_count_enable

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [1:0]  MODE_RST = 2'h0;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CNT_TOP  = 16'hffff;

endpackage

/* src/tt_edge_smp.sv */
// Pin sampler: two-flop synchroniser, then one sample per machine
// cycle; flags a high sample followed by a low sample.
// Assumes smp_en is a one-cycle pulse once per machine cycle.
`timescale 1ns/1ps
`default_nettype none
module tt_edge_smp (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Sampling
  input  wire logic smp_en,
  input  wire logic pin_i,
  output logic      level_r,
  output logic      fall_r
);
  logic sy1_r;
  logic sy2_r;
  logic level_nxt;
  logic fall_nxt;

  // ----------------------------------------------------------------
  // Next sample and edge
  // ----------------------------------------------------------------
  always_comb begin
    level_nxt = smp_en ? sy2_r : level_r;
    fall_nxt  = smp_en & level_r & ~sy2_r;
  end

  // Synchroniser and sample registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sy1_r   <= 1'b1;
      sy2_r   <= 1'b1;
      level_r <= 1'b1;
      fall_r  <= 1'b0;
    end else begin
      sy1_r   <= pin_i;
      sy2_r   <= sy1_r;
      level_r <= level_nxt;
      fall_r  <= fall_nxt;
    end
  end

endmodule
`default_nettype wire

/* src/tt_timer.sv */
// Third 16-bit timer/counter with capture, auto-reload, baud-rate and
// clock-out modes, reached by software over APB.
// Assumes clk_sys is the oscillator clock; pins are asynchronous.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tt_timer
  import tt_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // External pins
  input  wire logic              count_input_pin,
  input  wire logic              trigger_direction_pin,
  output logic                   port1_bit0_pin_o,
  output logic                   port1_bit0_pin_oe_n,
  // Serial port and interrupt
  output logic                   rx_baud_tick,
  output logic                   tx_baud_tick,
  output logic                   timer_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [3:0]  phase_r,   phase_nxt;
  logic [7:0]  ctrl_r,    ctrl_nxt;
  logic [1:0]  mode_r,    mode_nxt;
  logic [15:0] cnt_r,     cnt_nxt;
  logic [15:0] rcap_r,    rcap_nxt;
  logic [3:0]  div_r,     div_nxt;
  logic        pend_r,    pend_nxt;
  logic        clko_r,    clko_nxt;
  logic        oe_n_r,    oe_n_nxt;
  logic        rxt_r,     rxt_nxt;
  logic        txt_r,     txt_nxt;
  logic        irq_r,     irq_nxt;
  logic [31:0] prdata_r,  prdata_nxt;
  logic        pready_r,  pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic        smp_en, vis_en, state_en;
  logic        cnt_fall, trig_fall, trig_level;
  logic        baud_m, clko_m, fast_m, updn_m, down_m, reload_m;
  logic        run, exen, cts, cprl;
  logic        cnt_en, wrap_up, wrap_dn, trig_act;
  logic [7:0]  idx;
  logic        hit, wr_en;

  // ----------------------------------------------------------------
  // Machine-cycle phase divider
  // ----------------------------------------------------------------
  always_comb begin
    phase_nxt = (phase_r == PH_LAST) ? 4'h0 : phase_r + 4'h1;
  end

  // one visible step per machine cycle
  assign smp_en   = (phase_r == PH_SAMPLE);
  assign vis_en   = (phase_r == PH_VISIBLE);
  assign state_en = phase_r[0];

  tt_edge_smp u_cnt_smp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .smp_en  (smp_en),
    .pin_i   (count_input_pin),
    .level_r (),
    .fall_r  (cnt_fall)
  );

  tt_edge_smp u_trig_smp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .smp_en  (smp_en),
    .pin_i   (trigger_direction_pin),
    .level_r (trig_level),
    .fall_r  (trig_fall)
  );

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign run    = ctrl_r[CB_RUN];
  assign exen   = ctrl_r[CB_EXEN];
  assign cts    = ctrl_r[CB_CT];
  assign cprl   = ctrl_r[CB_CPRL];
  // baud select wins over capture/reload select
  assign baud_m = ctrl_r[CB_RXB] | ctrl_r[CB_TXB];
  // clock-out needs timer function and output enable
  assign clko_m = mode_r[MB_OE] & ~cts;
  assign fast_m = (baud_m | clko_m) & ~cts;
  assign reload_m = baud_m | clko_m | ~cprl;
  assign updn_m   = mode_r[MB_DOWN] & ~baud_m & ~cprl;
  assign down_m   = updn_m & ~trig_level;

  // count only while running; state-time rate; visible step
  assign cnt_en  = run & (fast_m ? state_en : (cts ? (vis_en & pend_r) : vis_en));
  assign wrap_up = cnt_en & ~down_m & (cnt_r == CNT_TOP);
  assign wrap_dn = cnt_en & down_m & (cnt_r == rcap_r);
  assign trig_act = trig_fall & exen & ~updn_m;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx   = paddr[9:2];
  assign hit   = (paddr[1:0] == 2'h0) &&
                 (idx >= IDX_CTRL) && (idx <= IDX_CNT_H);
  assign wr_en = psel & penable & pwrite & pready_r & hit;

  // ----------------------------------------------------------------
  // Counter, flags and software writes
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    mode_nxt = mode_r;
    cnt_nxt  = cnt_r;
    rcap_nxt = rcap_r;
    div_nxt  = div_r;
    clko_nxt = clko_r;
    rxt_nxt  = 1'b0;
    txt_nxt  = 1'b0;
    // edge waits for the next visible phase
    pend_nxt = cnt_fall ? 1'b1 : (vis_en ? 1'b0 : pend_r);
    // Software writes; hardware events below win on flags
    if (wr_en) begin
      case (idx)
        IDX_CTRL:   ctrl_nxt = pwdata[7:0];
        IDX_MODE:   mode_nxt = pwdata[1:0];
        IDX_RCAP_L: rcap_nxt[7:0]  = pwdata[7:0];
        IDX_RCAP_H: rcap_nxt[15:8] = pwdata[7:0];
        IDX_CNT_L:  cnt_nxt[7:0]   = pwdata[7:0];
        IDX_CNT_H:  cnt_nxt[15:8]  = pwdata[7:0];
        default:    ctrl_nxt = ctrl_r;
      endcase
    end
    if (cnt_en) begin
      if (wrap_dn) begin
        cnt_nxt = CNT_TOP;
        ctrl_nxt[CB_OVF] = 1'b1;
        ctrl_nxt[CB_EXT] = ~ctrl_r[CB_EXT];
      end else if (down_m) begin
        cnt_nxt = cnt_r - 16'h0001;
      end else if (wrap_up) begin
        // reload on rollover; capture mode wraps to zero
        cnt_nxt = reload_m ? rcap_r : CNT_RST;
        // baud and clock-out rollovers set no overflow flag
        if (!(baud_m || clko_m)) begin
          ctrl_nxt[CB_OVF] = 1'b1;
        end
        if (updn_m) begin
          ctrl_nxt[CB_EXT] = ~ctrl_r[CB_EXT];
        end
        if (baud_m) begin
          div_nxt = div_r + 4'h1;
          rxt_nxt = (div_r == BAUD_DIV_LAST) & ctrl_r[CB_RXB];
          txt_nxt = (div_r == BAUD_DIV_LAST) & ctrl_r[CB_TXB];
        end
        if (clko_m) begin
          clko_nxt = ~clko_r;
        end
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
    if (trig_act) begin
      ctrl_nxt[CB_EXT] = 1'b1;
      if (!baud_m) begin
        if (cprl) begin
          rcap_nxt = cnt_r;
        end else begin
          cnt_nxt = rcap_r;
        end
      end
    end
    // pin released unless clock-out is selected
    oe_n_nxt = ~clko_m;
    // OR of flags; edge flag silent in up/down mode
    irq_nxt  = ctrl_nxt[CB_OVF] | (ctrl_nxt[CB_EXT] & ~(mode_nxt[MB_DOWN] &
               ~ctrl_nxt[CB_RXB] & ~ctrl_nxt[CB_TXB] & ~ctrl_nxt[CB_CPRL]));
  end

  // ----------------------------------------------------------------
  // APB answer: ready in first access cycle
  // ----------------------------------------------------------------
  always_comb begin
    pready_nxt  = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~hit;
    prdata_nxt  = 32'h0000_0000;
    if (psel && !penable && hit) begin
      case (idx)
        IDX_CTRL:   prdata_nxt[7:0] = ctrl_r;
        IDX_MODE:   prdata_nxt[1:0] = mode_r;
        IDX_RCAP_L: prdata_nxt[7:0] = rcap_r[7:0];
        IDX_RCAP_H: prdata_nxt[7:0] = rcap_r[15:8];
        IDX_CNT_L:  prdata_nxt[7:0] = cnt_r[7:0];
        IDX_CNT_H:  prdata_nxt[7:0] = cnt_r[15:8];
        default:    prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_r   <= 4'h0;
      ctrl_r    <= CTRL_RST;
      mode_r    <= MODE_RST;
      cnt_r     <= CNT_RST;
      rcap_r    <= CNT_RST;
      div_r     <= 4'h0;
      pend_r    <= 1'b0;
      clko_r    <= 1'b0;
      oe_n_r    <= 1'b1;
      rxt_r     <= 1'b0;
      txt_r     <= 1'b0;
      irq_r     <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      ctrl_r    <= ctrl_nxt;
      mode_r    <= mode_nxt;
      cnt_r     <= cnt_nxt;
      rcap_r    <= rcap_nxt;
      div_r     <= div_nxt;
      pend_r    <= pend_nxt;
      clko_r    <= clko_nxt;
      oe_n_r    <= oe_n_nxt;
      rxt_r     <= rxt_nxt;
      txt_r     <= txt_nxt;
      irq_r     <= irq_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign port1_bit0_pin_o    = clko_r;
  assign port1_bit0_pin_oe_n = oe_n_r;
  assign rx_baud_tick        = rxt_r;
  assign tx_baud_tick        = txt_r;
  assign timer_irq           = irq_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // slow timer steps once per machine cycle
  mach_rate_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (run && !fast_m && !cts && !down_m && !wrap_up && !wr_en && !trig_act) |=>
      (cnt_r == $past(cnt_r) + (($past(phase_r) == PH_VISIBLE) ? 16'h0001 : 16'h0000)))
    else $error("timer step at wrong rate");

  state_rate_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (run && fast_m && !wr_en && !trig_act && !wrap_up && !down_m) |->
      ##1 (cnt_r == $past(cnt_r) + 16'h0001) ##1 $stable(cnt_r) or
      ##1 $stable(cnt_r) ##1 1'b1)
    else $error("baud rate step wrong");

  ovf_reload_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wrap_up && !cprl && !baud_m && !clko_m && !trig_act && !wr_en) |=>
      (cnt_r == $past(rcap_r)) && ctrl_r[CB_OVF])
    else $error("overflow did not reload");

  under_top_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wrap_dn && !wr_en) |=> (cnt_r == CNT_TOP) && ctrl_r[CB_OVF] &&
      (ctrl_r[CB_EXT] != $past(ctrl_r[CB_EXT])))
    else $error("underflow handling wrong");

  capture_copy_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (trig_act && cprl && !baud_m && !wr_en) |=>
      (rcap_r == $past(cnt_r)) && ctrl_r[CB_EXT])
    else $error("capture missed");

  // baud rollover sets no overflow flag
  baud_noflag_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wrap_up && baud_m && !ctrl_r[CB_OVF] && !wr_en) |=> !ctrl_r[CB_OVF])
    else $error("baud rollover set flag");

  hold_stop_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!run && !wr_en && !trig_act) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  reset_up_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> !mode_r[MB_DOWN])
    else $error("down count set after reset");

  irq_or_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    ##1 (timer_irq == (ctrl_r[CB_OVF] | (ctrl_r[CB_EXT] & ~updn_m))))
    else $error("interrupt not OR of flags");

endmodule
`default_nettype wire

/* testbench/tt_pin_model.sv */
// Pin-side model: external count source and trigger/direction source.
// Assumes clk_sys is the block clock; both pins idle high on pull-ups.
`timescale 1ns/1ps
`default_nettype none
module tt_pin_model (
  // Clock
  input  wire logic clk_sys,
  // Pins toward the timer
  output logic      count_input_pin,
  output logic      trigger_direction_pin
);
  localparam int HOLD = 14;  // Clocks per level, above one machine cycle

  // Pulled-up idle level
  initial begin
    count_input_pin = 1'b1;
    trigger_direction_pin = 1'b1;
  end

  // each level held a full cycle
  task automatic pulse(input bit trig, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (trig) trigger_direction_pin <= 1'b0;
      else count_input_pin <= 1'b0;
      repeat (HOLD) @(posedge clk_sys);
      if (trig) trigger_direction_pin <= 1'b1;
      else count_input_pin <= 1'b1;
      repeat (HOLD) @(posedge clk_sys);
    end
  endtask

  // direction level held a full cycle
  task automatic level(input logic v);
    @(posedge clk_sys);
    trigger_direction_pin <= v;
    repeat (HOLD) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the third timer/counter over APB.
// Assumes tt_pkg register indices; pins come from tt_pin_model.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tt_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rst     = 1'b1;
  logic              psel    = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite  = 1'b0;
  logic [ADDR_W-1:0] paddr   = '0;
  logic [31:0]       pwdata  = '0;
  wire logic [31:0]  prdata;
  wire logic         pready, pslverr, cnt_pin, trig_pin, pin_o, oe_n;
  wire logic         rx_tick, tx_tick, irq;
  int                mismatches, compares;
  logic [31:0]       rdat, cflags, gapv, v16;
  logic              irqv, errv;
  logic              rx_seen = 1'b0;

  tt_timer tt_timer_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_input_pin(cnt_pin), .trigger_direction_pin(trig_pin),
    .port1_bit0_pin_o(pin_o), .port1_bit0_pin_oe_n(oe_n),
    .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .timer_irq(irq));
  tt_pin_model tt_pin_model_inst (.clk_sys(clk_sys),
    .count_input_pin(cnt_pin), .trigger_direction_pin(trig_pin));

  // Clock and sticky receive tick
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (rx_tick === 1'b1) rx_seen <= 1'b1;

  // ----------------------------------------------------------------
  // Bus cycles and checks
  // ----------------------------------------------------------------
  task automatic apb(input bit wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d});
  endtask
  task automatic set16(input logic [7:0] idx, input logic [15:0] v);
    w(idx, v[7:0]);
    w(idx + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
    v16 = {24'h0, rdat[7:0]};
    apb(1'b0, idx + 8'h01, 32'h0);
    v16[15:8] = rdat[7:0];
  endtask
  // Runs exactly n clocks, reads flags near the end, then stops
  task automatic run(input logic [7:0] c, input int n, input logic [7:0] off);
    w(IDX_CTRL, c);
    repeat (n - 6) @(posedge clk_sys);
    apb(1'b0, IDX_CTRL, 32'h0);
    cflags = rdat;
    irqv = irq;
    w(IDX_CTRL, off);
  endtask
  function automatic logic pick(bit s);
    return s ? pin_o : tx_tick;
  endfunction
  // Clocks from one high sample of a signal to its next rising
  task automatic gap(input bit s, output logic [31:0] g);
    int k;
    k = 0;
    g = 0;
    while (pick(s) !== 1'b1 && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    do begin @(posedge clk_sys); g++; end while (pick(s) === 1'b1 && g < 300);
    do begin @(posedge clk_sys); g++; end while (pick(s) !== 1'b1 && g < 300);
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, IDX_CTRL + 8'(i), 32'h0);
      chk32(rdat, 32'h0);
      chk1(errv, 1'b0);
    end
    apb(1'b0, 8'h00, 32'h0);
    chk1(errv, 1'b1);
    chk1(oe_n, 1'b1);
    chk1(irq, 1'b0);
    done("reset");
  endtask
  task automatic t_timer;
    set16(IDX_CNT_L, 16'h0000);
    run(8'h04, 120, 8'h00);
    rd16(IDX_CNT_L);
    chk32(v16, 32'd10);
    repeat (40) @(posedge clk_sys);
    rd16(IDX_CNT_L);
    chk32(v16, 32'd10);
    done("timer");
  endtask
  task automatic t_ovf;
    set16(IDX_RCAP_L, 16'hfff0);
    set16(IDX_CNT_L, 16'hfffe);
    run(8'h04, 36, 8'h00);
    chk32(cflags, 32'h84);
    chk1(irqv, 1'b1);
    rd16(IDX_CNT_L);
    chk32(v16, 32'hfff1);
    repeat (3) @(posedge clk_sys);
    chk1(irq, 1'b0);
    done("overflow");
  endtask
  task automatic t_updown;
    w(IDX_MODE, 8'h01);
    set16(IDX_RCAP_L, 16'h0010);
    set16(IDX_CNT_L, 16'h0011);
    tt_pin_model_inst.level(1'b0);
    run(8'h04, 36, 8'h40);
    chk32(cflags, 32'hc4);
    rd16(IDX_CNT_L);
    chk32(v16, 32'hfffe);
    chk1(irq, 1'b0);
    tt_pin_model_inst.level(1'b1);
    set16(IDX_CNT_L, 16'hfffe);
    run(8'h04, 36, 8'h00);
    chk32(cflags, 32'hc4);
    rd16(IDX_CNT_L);
    chk32(v16, 32'h0011);
    w(IDX_MODE, 8'h00);
    done("updown");
  endtask
  task automatic t_capture;
    set16(IDX_CNT_L, 16'h1234);
    set16(IDX_RCAP_L, 16'h0000);
    w(IDX_CTRL, 8'h07);
    tt_pin_model_inst.pulse(1'b1, 1);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk32(rdat, 32'h07);
    rd16(IDX_RCAP_L);
    chk32(v16, 32'h0);
    w(IDX_CTRL, 8'h0f);
    tt_pin_model_inst.pulse(1'b1, 1);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk32(rdat, 32'h4f);
    chk1(irq, 1'b1);
    rd16(IDX_RCAP_L);
    chk32(v16, 32'h1234);
    set16(IDX_CNT_L, 16'hfffe);
    run(8'h05, 36, 8'h00);
    chk32(cflags, 32'h85);
    rd16(IDX_CNT_L);
    chk32(v16, 32'h0001);
    w(IDX_CTRL, 8'h00);
    done("capture");
  endtask
  task automatic t_reload;
    set16(IDX_CNT_L, 16'h0042);
    w(IDX_CTRL, 8'h08);
    tt_pin_model_inst.pulse(1'b1, 1);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk32(rdat, 32'h48);
    chk1(irq, 1'b1);
    rd16(IDX_CNT_L);
    chk32(v16, 32'h1234);
    w(IDX_CTRL, 8'h00);
    done("reload");
  endtask
  task automatic t_count;
    set16(IDX_CNT_L, 16'h0000);
    w(IDX_CTRL, 8'h06);
    tt_pin_model_inst.pulse(1'b0, 5);
    repeat (30) @(posedge clk_sys);
    w(IDX_CTRL, 8'h00);
    rd16(IDX_CNT_L);
    chk32(v16, 32'd5);
    done("count");
  endtask
  task automatic t_baud;
    set16(IDX_RCAP_L, 16'hfffe);
    set16(IDX_CNT_L, 16'hfffe);
    w(IDX_CTRL, 8'h1d);
    gap(1'b0, gapv);
    chk32(gapv, 32'd64);
    tt_pin_model_inst.pulse(1'b1, 1);
    repeat (30) @(posedge clk_sys);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk32(rdat, 32'h5d);
    chk1(rx_seen, 1'b0);
    w(IDX_CTRL, 8'h24);
    repeat (80) @(posedge clk_sys);
    chk1(rx_seen, 1'b1);
    w(IDX_CTRL, 8'h00);
    done("baud");
  endtask
  task automatic t_clkout;
    w(IDX_MODE, 8'h02);
    w(IDX_CTRL, 8'h04);
    gap(1'b1, gapv);
    chk32(gapv, 32'd8);
    chk1(oe_n, 1'b0);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk32(rdat, 32'h04);
    chk1(irq, 1'b0);
    w(IDX_CTRL, 8'h00);
    w(IDX_MODE, 8'h00);
    done("clkout");
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_timer;
    t_ovf;
    t_updown;
    t_capture;
    t_reload;
    t_count;
    t_baud;
    t_clkout;
    finish_test;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
